// ### src/qcnt_pkg.sv
// Register map, field layout and reset values of the quadrature counter registers
package qcnt_pkg;

  localparam int ADR_W  = 6;
  localparam int DAT_W  = 32;
  localparam int WORD_W = 16;
  localparam int NUM_EV = 4;

  // Byte addresses, one aligned word each
  localparam logic [ADR_W-1:0] OFS_STATUS   = 6'h00;
  localparam logic [ADR_W-1:0] OFS_POS_LOW  = 6'h04;
  localparam logic [ADR_W-1:0] OFS_POS_HIGH = 6'h08;
  localparam logic [ADR_W-1:0] OFS_POS_HOLD = 6'h0c;
  localparam logic [ADR_W-1:0] OFS_VEL_LOW  = 6'h10;
  localparam logic [ADR_W-1:0] OFS_VEL_HIGH = 6'h14;
  localparam logic [ADR_W-1:0] OFS_VEL_HOLD = 6'h18;
  localparam logic [ADR_W-1:0] OFS_TMR_LOW  = 6'h1c;
  localparam logic [ADR_W-1:0] OFS_TMR_HIGH = 6'h20;
  localparam logic [ADR_W-1:0] OFS_IRQ_CLR  = 6'h24;
  localparam logic [ADR_W-1:0] OFS_IRQ_EN   = 6'h28;

  // Event numbers; event n has its enable at bit 2n and its flag at bit 2n+1
  localparam int EV_INDEX = 0;
  localparam int EV_HOME  = 1;
  localparam int EV_VELOV = 2;
  localparam int EV_HDONE = 3;

  // Position init modes in which the homing-done flag is meaningful
  localparam logic [2:0] PIM_HOME_FIRST = 3'h3;
  localparam logic [2:0] PIM_HOME_NEXT  = 3'h4;

  localparam logic [DAT_W-1:0]  CNT_RESET  = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [DAT_W-1:0]  CNT_STEP   = 32'h0000_0001;
  localparam logic [DAT_W-1:0]  MASK_WIDE  = 32'hffff_ffff;
  localparam logic [DAT_W-1:0]  MASK_NARROW = 32'h0000_ffff;

endpackage

// ### src/event_irq_if.sv
// Carrier between the register core and the event flag block
`timescale 1ns/1ps
interface event_irq_if;
  import qcnt_pkg::*;
  logic [NUM_EV-1:0] evt;   // Event pulses
  logic [NUM_EV-1:0] clr;   // Clear pulses from software
  logic [NUM_EV-1:0] en;    // Interrupt enables
  logic [NUM_EV-1:0] flag;  // Sticky flags
  logic              irq;   // Registered interrupt level

  modport core (output evt, output clr, output en, input flag, input irq);
  modport flags (input evt, input clr, input en, output flag, output irq);
endinterface

// ### src/event_flags.sv
// Sticky event flags and the gated interrupt level
`timescale 1ns/1ps
module event_flags
(
  input  wire logic    clk_i,  // Peripheral clock
  input  wire logic    rst_i,  // Synchronous reset, active high
  event_irq_if.flags   ev      // Events, clears and enables in; flags, irq out
);
  import qcnt_pkg::*;

  typedef struct packed {
    logic [NUM_EV-1:0] flag;
    logic              irq;
  } flag_state_t;

  flag_state_t s_q;
  flag_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    // Set wins over clear so an event in the clearing cycle is kept
    s_d.flag = (s_q.flag & ~ev.clr) | ev.evt;
    s_d.irq  = |(s_d.flag & ev.en);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign ev.flag = s_q.flag;
  assign ev.irq  = s_q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_flag_held_low: assert property ($rose(s_q.flag[EV_INDEX]) |-> $past(ev.evt[EV_INDEX]))
    else $error("index flag rose without an index event");
  a_flag_sticky: assert property (s_q.flag[EV_HOME] && !ev.clr[EV_HOME] |=> s_q.flag[EV_HOME])
    else $error("home flag dropped without a clear");
  a_event_sets: assert property (ev.evt[EV_INDEX] && ev.clr[EV_INDEX] |=> s_q.flag[EV_INDEX])
    else $error("index event lost during clear");
  a_irq_level: assert property (##1 s_q.irq == |($past(s_q.flag & ~ev.clr | ev.evt) & $past(ev.en)))
    else $error("interrupt level does not follow flags and enables");
  a_home_irq: assert property (ev.en[EV_HOME] && ev.evt[EV_HOME] |=> s_q.irq)
    else $error("enabled home event raised no interrupt");
endmodule

// ### src/quadrature_counter_registers.sv
// Position, velocity and interval counters with event status over classic Wishbone
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module quadrature_counter_registers
#(
  parameter int VEL_WIDE = 1  // 1 builds the velocity upper word and holding register
)
(
  input  wire logic                        clk_i,           // Peripheral clock
  input  wire logic                        rst_i,           // Synchronous reset
  input  wire logic                        cyc_i,           // Wishbone cycle
  input  wire logic                        stb_i,           // Wishbone strobe
  input  wire logic                        we_i,            // Wishbone write
  input  wire logic [qcnt_pkg::ADR_W-1:0]  adr_i,           // Wishbone byte address
  input  wire logic [3:0]                  sel_i,           // Wishbone byte lanes
  input  wire logic [qcnt_pkg::DAT_W-1:0]  dat_i,           // Wishbone write data
  output logic      [qcnt_pkg::DAT_W-1:0]  dat_o,           // Wishbone read data
  output logic                             ack_o,           // Wishbone acknowledge
  input  wire logic                        count_up_i,      // Decoded step forward
  input  wire logic                        count_down_i,    // Decoded step backward
  input  wire logic                        index_event_i,   // Index event pulse
  input  wire logic                        home_event_i,    // Home event pulse
  input  wire logic                        homing_done_i,   // Position reinitialised
  input  wire logic [2:0]                  position_init_mode_i, // Init mode field
  output logic                             irq_o            // Interrupt level
);
  import qcnt_pkg::*;

  if (VEL_WIDE != 0 && VEL_WIDE != 1)
  begin : g_bad_param
    $error("VEL_WIDE must be 0 or 1");
  end

  localparam logic [DAT_W-1:0] VEL_MASK = (VEL_WIDE == 1) ? MASK_WIDE : MASK_NARROW;

  typedef struct packed {
    logic              ack;
    logic [DAT_W-1:0]  rdata;
    logic [DAT_W-1:0]  position_counter;
    logic [WORD_W-1:0] position_upper_holding_value;
    logic [DAT_W-1:0]  velocity_counter;
    logic [WORD_W-1:0] velocity_upper_holding_value;
    logic [DAT_W-1:0]  interval_timer;
    logic [NUM_EV-1:0] irq_enable;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  event_irq_if ev ();

  event_flags u_flags
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ev    (ev.flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Only the two low byte lanes carry register data
  function automatic logic [WORD_W-1:0] lane_merge(input logic [WORD_W-1:0] old_v,
                                                   input logic [WORD_W-1:0] new_v,
                                                   input logic [1:0]        sel);
    logic [WORD_W-1:0] r;
    r = old_v;
    if (sel[0])
      r[7:0] = new_v[7:0];
    if (sel[1])
      r[15:8] = new_v[15:8];
    return r;
  endfunction

  logic              req;
  logic              wr;
  logic              rd;
  logic              step_up;
  logic              step_dn;
  logic              vel_wrap;
  logic [WORD_W-1:0] wword;
  logic              mode_homing;

  assign req         = cyc_i & stb_i & ~s_q.ack;
  assign wr          = req & we_i;
  assign rd          = req & ~we_i;
  assign step_up     = count_up_i & ~count_down_i;
  assign step_dn     = count_down_i & ~count_up_i;
  assign wword       = dat_i[WORD_W-1:0];
  assign mode_homing = (position_init_mode_i == PIM_HOME_FIRST) ||
                       (position_init_mode_i == PIM_HOME_NEXT);
  // Overflow in either direction at the configured velocity width
  assign vel_wrap    = (step_up && s_q.velocity_counter == VEL_MASK) ||
                       (step_dn && s_q.velocity_counter == CNT_RESET);

  ////////////////////////////////////////////////////////////////////////////////
  // Events and clears towards the flag block

  assign ev.evt[EV_INDEX] = index_event_i;
  assign ev.evt[EV_HOME]  = home_event_i;
  assign ev.evt[EV_VELOV] = vel_wrap;
  assign ev.evt[EV_HDONE] = homing_done_i & mode_homing;
  assign ev.en            = s_q.irq_enable;

  for (genvar g = 0; g < NUM_EV; g++)
  begin : g_clear
    // Write one to a flag position of the clear register clears it
    assign ev.clr[g] = wr && adr_i == OFS_IRQ_CLR && sel_i[(2*g+1)/8] && dat_i[2*g+1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d       = s_q;
    s_d.ack   = req;
    s_d.rdata = '0;

    // Counting; a software write in the same cycle takes precedence below
    if (step_up)
    begin
      s_d.position_counter = s_q.position_counter + CNT_STEP;
      s_d.velocity_counter = (s_q.velocity_counter + CNT_STEP) & VEL_MASK;
    end
    else if (step_dn)
    begin
      s_d.position_counter = s_q.position_counter - CNT_STEP;
      s_d.velocity_counter = (s_q.velocity_counter - CNT_STEP) & VEL_MASK;
    end
    s_d.interval_timer = s_q.interval_timer + CNT_STEP;

    if (rd)
    begin
      case (adr_i)
        OFS_STATUS, OFS_IRQ_EN:
        begin
          for (int i = 0; i < NUM_EV; i++)
          begin
            s_d.rdata[2*i] = s_q.irq_enable[i];
            if (adr_i == OFS_STATUS)
              s_d.rdata[2*i+1] = ev.flag[i];
          end
        end
        OFS_POS_LOW:
        begin
          s_d.rdata[WORD_W-1:0] = s_q.position_counter[WORD_W-1:0];
          s_d.position_upper_holding_value = s_q.position_counter[DAT_W-1:WORD_W];
        end
        OFS_POS_HIGH:
          s_d.rdata[WORD_W-1:0] = s_q.position_counter[DAT_W-1:WORD_W];
        OFS_POS_HOLD:
          s_d.rdata[WORD_W-1:0] = s_q.position_upper_holding_value;
        OFS_VEL_LOW:
        begin
          s_d.rdata[WORD_W-1:0] = s_q.velocity_counter[WORD_W-1:0];
          if (VEL_WIDE == 1)
            s_d.velocity_upper_holding_value = s_q.velocity_counter[DAT_W-1:WORD_W];
        end
        OFS_VEL_HIGH:
          if (VEL_WIDE == 1)
            s_d.rdata[WORD_W-1:0] = s_q.velocity_counter[DAT_W-1:WORD_W];
        OFS_VEL_HOLD:
          if (VEL_WIDE == 1)
            s_d.rdata[WORD_W-1:0] = s_q.velocity_upper_holding_value;
        OFS_TMR_LOW:
          s_d.rdata[WORD_W-1:0] = s_q.interval_timer[WORD_W-1:0];
        OFS_TMR_HIGH:
          s_d.rdata[WORD_W-1:0] = s_q.interval_timer[DAT_W-1:WORD_W];
        default:
          s_d.rdata = '0;
      endcase
    end

    if (wr)
    begin
      case (adr_i)
        OFS_STATUS, OFS_IRQ_EN:
        begin
          for (int i = 0; i < NUM_EV; i++)
            if (sel_i[0])
              s_d.irq_enable[i] = dat_i[2*i];
        end
        OFS_POS_LOW:
          // The full 32 bits change in one cycle, so a count never tears
          s_d.position_counter = {s_q.position_upper_holding_value,
                                  lane_merge(s_q.position_counter[WORD_W-1:0], wword,
                                             sel_i[1:0])};
        OFS_POS_HIGH:
          s_d.position_counter[DAT_W-1:WORD_W] =
            lane_merge(s_q.position_counter[DAT_W-1:WORD_W], wword, sel_i[1:0]);
        OFS_POS_HOLD:
          s_d.position_upper_holding_value =
            lane_merge(s_q.position_upper_holding_value, wword, sel_i[1:0]);
        OFS_VEL_LOW:
          if (VEL_WIDE == 1)
            s_d.velocity_counter = {s_q.velocity_upper_holding_value,
                                    lane_merge(s_q.velocity_counter[WORD_W-1:0], wword,
                                               sel_i[1:0])};
          else
            s_d.velocity_counter = {WORD_RESET,
                                    lane_merge(s_q.velocity_counter[WORD_W-1:0], wword,
                                               sel_i[1:0])};
        OFS_VEL_HIGH:
          if (VEL_WIDE == 1)
            s_d.velocity_counter[DAT_W-1:WORD_W] =
              lane_merge(s_q.velocity_counter[DAT_W-1:WORD_W], wword, sel_i[1:0]);
        OFS_VEL_HOLD:
          if (VEL_WIDE == 1)
            s_d.velocity_upper_holding_value =
              lane_merge(s_q.velocity_upper_holding_value, wword, sel_i[1:0]);
        OFS_TMR_LOW:
          s_d.interval_timer[WORD_W-1:0] =
            lane_merge(s_q.interval_timer[WORD_W-1:0], wword, sel_i[1:0]);
        OFS_TMR_HIGH:
          s_d.interval_timer[DAT_W-1:WORD_W] =
            lane_merge(s_q.interval_timer[DAT_W-1:WORD_W], wword, sel_i[1:0]);
        default:
          s_d.irq_enable = s_q.irq_enable;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign dat_o = s_q.rdata;
  assign ack_o = s_q.ack;
  assign irq_o = ev.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("acknowledge held for more than one cycle");
  a_low_read_latch: assert property (rd && adr_i == OFS_POS_LOW |=>
      s_q.position_upper_holding_value == $past(s_q.position_counter[DAT_W-1:WORD_W]))
    else $error("low word read did not latch the upper position word");
  a_low_write_load: assert property (wr && adr_i == OFS_POS_LOW && sel_i[1:0] == 2'h3 |=>
      s_q.position_counter == {$past(s_q.position_upper_holding_value), $past(wword)})
    else $error("low word write did not load all 32 position bits");
  a_pos_low_data: assert property (rd && adr_i == OFS_POS_LOW |=>
      ack_o && dat_o == {WORD_RESET, $past(s_q.position_counter[WORD_W-1:0])})
    else $error("position low word read returned wrong data");
  a_pos_high_data: assert property (rd && adr_i == OFS_POS_HIGH |=>
      dat_o[WORD_W-1:0] == $past(s_q.position_counter[DAT_W-1:WORD_W]))
    else $error("position high word read returned wrong data");
  a_hold_write: assert property (wr && adr_i == OFS_POS_HOLD && sel_i[1:0] == 2'h3 |=>
      s_q.position_upper_holding_value == $past(wword))
    else $error("position holding write not stored");
  a_vel_narrow: assert property ((s_q.velocity_counter & ~VEL_MASK) == CNT_RESET)
    else $error("velocity bits beyond the built width are set");
  // The reset term keeps the release edge out: the timer restarts from zero there
  a_timer_runs: assert property (!rst_i && !(wr && (adr_i == OFS_TMR_LOW || adr_i == OFS_TMR_HIGH)) |=>
      s_q.interval_timer == $past(s_q.interval_timer) + CNT_STEP)
    else $error("interval timer did not advance");
  a_reset_clear: assert property (disable iff (1'b0) $past(rst_i) |->
      s_q.position_counter == CNT_RESET && s_q.velocity_counter == CNT_RESET &&
      s_q.interval_timer == CNT_RESET && s_q.position_upper_holding_value == WORD_RESET)
    else $error("counters not zero after reset");
  a_hdone_gated: assert property (!mode_homing |-> !ev.evt[EV_HDONE])
    else $error("homing done flagged outside homing modes");
  a_idx_enable: assert property (s_q.irq_enable[EV_INDEX] && index_event_i |=> irq_o)
    else $error("enabled index event raised no interrupt");
endmodule

// ### sim/testbench.sv
// Self-checking bench for the quadrature counter registers
`timescale 1ns/1ps
module testbench;
  import qcnt_pkg::*;

  logic              clk_i;
  logic              rst_i;
  logic              cyc_i;
  logic              stb_i;
  logic              we_i;
  logic [ADR_W-1:0]  adr_i;
  logic [3:0]        sel_i;
  logic [DAT_W-1:0]  dat_i;
  logic [DAT_W-1:0]  dat_o;
  logic [DAT_W-1:0]  dat_n;
  logic              ack_o;
  logic              count_up_i;
  logic              count_down_i;
  logic              index_event_i;
  logic              home_event_i;
  logic              homing_done_i;
  logic [2:0]        position_init_mode_i;
  logic              irq_o;
  int                error_cnt;
  int                checked;
  int                cyc_n;
  int                t1;
  int                t2;
  logic [31:0]       seed;
  logic [31:0]       pos_m;
  logic [31:0]       vel_m;
  logic [31:0]       rd;
  logic [31:0]       rd2;
  logic [31:0]       rd_n;

  quadrature_counter_registers #(.VEL_WIDE(1)) uut
  (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .count_up_i, .count_down_i, .index_event_i, .home_event_i, .homing_done_i,
    .position_init_mode_i, .irq_o
  );

  // A narrow build shares the bus and answers in step; only its read data is watched
  quadrature_counter_registers #(.VEL_WIDE(0)) uut_narrow
  (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o (dat_n),
    .ack_o (), .count_up_i, .count_down_i, .index_event_i, .home_event_i, .homing_done_i,
    .position_init_mode_i, .irq_o ()
  );

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Cycle stamps let timer checks measure real bus spacing instead of assuming it
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction
  function automatic logic [31:0] lo_w(input logic [31:0] v);
    return {16'h0000, v[15:0]};
  endfunction
  function automatic logic [31:0] hi_w(input logic [31:0] v);
    return {16'h0000, v[31:16]};
  endfunction
  function automatic logic hd_ok(input logic [2:0] m);
    return (m == PIM_HOME_FIRST) || (m == PIM_HOME_NEXT);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      complete_run();
    end
    q = dat_o;
    rd_n = dat_n;
    t1 = cyc_n;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [ADR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // Hold first, then low, so all 32 bits land together
  task automatic ld32(input logic [ADR_W-1:0] lo, input logic [ADR_W-1:0] hd,
                      input logic [31:0] v);
    wr(hd, hi_w(v));
    wr(lo, lo_w(v));
  endtask

  task automatic chk32(input logic [ADR_W-1:0] lo, input logic [ADR_W-1:0] hd,
                       input logic [31:0] v);
    rdc(lo, lo_w(v));
    rdc(hd, hi_w(v));
  endtask

  task automatic step(input logic up, input int n);
    @(posedge clk_i);
    count_up_i   <= up;
    count_down_i <= ~up;
    repeat (n) @(posedge clk_i);
    count_up_i   <= 1'b0;
    count_down_i <= 1'b0;
    pos_m = up ? pos_m + 32'(n) : pos_m - 32'(n);
    vel_m = up ? vel_m + 32'(n) : vel_m - 32'(n);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    index_event_i <= (k == 0);
    home_event_i  <= (k == 1);
    homing_done_i <= (k == 2);
    @(posedge clk_i);
    index_event_i <= 1'b0;
    home_event_i  <= 1'b0;
    homing_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = '0;
    sel_i = 4'h0;
    dat_i = '0;
    count_up_i = 1'b0;
    count_down_i = 1'b0;
    index_event_i = 1'b0;
    home_event_i = 1'b0;
    homing_done_i = 1'b0;
    position_init_mode_i = 3'h0;
    error_cnt = 0;
    checked = 0;
    seed = 32'he7e5dcd7;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
      rdc(6'(i * 4), 32'h0000_0000);
    rdc(OFS_IRQ_EN, 32'h0000_0000);
    chk(irq_o, 32'h0);
    $display("Test reset values done");

    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      pos_m = (k == 0) ? 32'h0000_ffff : (k == 1) ? 32'h0000_0000 : seed;
      vel_m = pos_m ^ 32'h5a5a_0f0f;
      ld32(OFS_POS_LOW, OFS_POS_HOLD, pos_m);
      ld32(OFS_VEL_LOW, OFS_VEL_HOLD, vel_m);
      rdc(OFS_POS_HIGH, hi_w(pos_m));
      rdc(OFS_VEL_HIGH, hi_w(vel_m));
      chk(rd_n, 32'h0000_0000);
      step(k != 1, (k < 2) ? 1 : int'(seed[3:0]) + 1);
      chk32(OFS_POS_LOW, OFS_POS_HOLD, pos_m);
      chk32(OFS_VEL_LOW, OFS_VEL_HOLD, vel_m);
      chk(rd_n, 32'h0000_0000);
    end
    wr(OFS_IRQ_CLR, 32'h0000_00aa);
    ld32(OFS_POS_LOW, OFS_POS_HOLD, 32'h0000_ffff);
    rdc(OFS_POS_LOW, 32'h0000_ffff);
    step(1'b1, 1);
    rdc(OFS_POS_HOLD, 32'h0000_0000);
    rdc(OFS_POS_HIGH, 32'h0000_0001);
    wr(OFS_POS_HIGH, 32'h0000_beef);
    rdc(OFS_POS_HIGH, 32'h0000_beef);
    ld32(OFS_VEL_LOW, OFS_VEL_HOLD, MASK_WIDE);
    step(1'b1, 1);
    chk32(OFS_VEL_LOW, OFS_VEL_HOLD, 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0020);
    chk(rd_n, 32'h0000_0020);
    wr(OFS_IRQ_CLR, 32'h0000_0020);
    $display("Test counters done");

    wr(OFS_TMR_LOW, 32'h0000_0000);
    wr(OFS_TMR_HIGH, 32'h0000_1234);
    rdc(OFS_TMR_HIGH, 32'h0000_1234);
    bus(1'b0, OFS_TMR_LOW, 32'h0, rd);
    t2 = t1;
    bus(1'b0, OFS_TMR_LOW, 32'h0, rd2);
    chk(rd2 - rd, 32'(t1 - t2));
    $display("Test interval timer done");

    pulse(0);
    rdc(OFS_STATUS, 32'h0000_0002);
    chk(irq_o, 32'h0);
    wr(OFS_IRQ_EN, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h1);
    rdc(OFS_STATUS, 32'h0000_0003);
    wr(OFS_IRQ_CLR, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h0);
    rdc(OFS_STATUS, 32'h0000_0001);
    pulse(1);
    chk(irq_o, 32'h0);
    rdc(OFS_STATUS, 32'h0000_0009);
    wr(OFS_STATUS, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h1);
    rdc(OFS_IRQ_EN, 32'h0000_0004);
    wr(OFS_IRQ_CLR, 32'h0000_0008);
    wr(OFS_IRQ_EN, 32'h0000_0040);
    for (int m = 0; m < 8; m++)
    begin
      position_init_mode_i <= 3'(m);
      pulse(2);
      chk(irq_o, {31'h0, hd_ok(3'(m))});
      rdc(OFS_STATUS, {24'h0, hd_ok(3'(m)), 7'h40});
      wr(OFS_IRQ_CLR, 32'h0000_0080);
    end
    $display("Test events done");

    rdc(6'h2c, 32'h0000_0000);
    wr(6'h3c, 32'h0000_ffff);
    rdc(OFS_IRQ_CLR, 32'h0000_0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(OFS_POS_HIGH, 32'h0000_0000);
    rdc(OFS_IRQ_EN, 32'h0000_0000);
    $display("Test unmapped and second reset done");
    complete_run();
  end
endmodule
